/* rtl/uki_key_install.sv */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - command starts at header byte, others dropped
// - missing terminator gives packet error
// - checksum mismatch gives checksum error
// - wrong length gives packet error
// - any failure abandons command, back to wait
// - lifecycle forbids command: acceptance error
// - unsupported key type: parameter error
// - span outside areas or straddling kinds: error
// - zero or misaligned write unit: parameter error
// - span beyond boundary: invalid address error
// - secure error at lowest or partial level
// - permanently protected block: protection error
// - checks pass: ok, host sends data packets
// - data packet starts at data start byte
// - data packet framing and reply code checked
// - payload count over install size: error
// - keep taking packets until payload complete
// - trusted system abnormal: silent, no write
// - index generation fails: trusted-system error
// - flash failure reports status and address
// - stored index: ok, back to wait
// - highest priority failure, filler elsewhere
module uki_key_install
    import uki_pkg::*;
#(
    parameter int KB_DEPTH = 1040
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic        tx_ready,
    input  wire logic        lc_ok,
    input  wire logic [1:0]  auth_lvl,
    output logic             ts_start,
    output logic      [7:0]  ts_ktype,
    input  wire logic        ts_done,
    input  wire logic        ts_fail,
    input  wire logic        ts_abn,
    input  wire logic [10:0] kb_addr,
    output logic      [7:0]  kb_data,
    output logic             fl_start,
    output logic      [31:0] fl_addr,
    output logic      [11:0] fl_len,
    input  wire logic        fl_done,
    input  wire logic        fl_err,
    input  wire logic [31:0] fl_sts,
    input  wire logic [31:0] fl_fadr
);
    uki_st_t     st_q;
    uki_rep_t    rep_q;
    logic        dm_q;
    logic        go_data_q;
    logic [15:0] len_q;
    logic [15:0] ix_q;
    logic [7:0]  sum_q;
    logic [7:0]  ctype_q;
    logic [7:0]  dres_q;
    logic [31:0] key_store_location_q;
    logic        etx_ok_q;
    logic        sum_ok_q;
    logic [10:0] cnt_q;
    logic [7:0]  kb_q [KB_DEPTH];
    logic [3:0]  tix_q;
    logic [7:0]  tsum_q;
    logic [31:0] rg_q [NREG-1];
    logic [7:0]  ev_sts;
    logic [10:0] isz;
    logic [11:0] ksz;
    logic [32:0] sb;
    logic [32:0] se;
    logic [16:0] tot;
    logic [16:0] wpos;
    logic        s0, s1, e0, e1;
    logic [7:0]  write_access_unit;
    logic        fits, same, acc, sec, prot;
    logic        tx_done;
    logic [3:0]  ri;
    logic        bad;

    function automatic logic inr(input logic [32:0] x, input logic [31:0] lo,
                                 input logic [31:0] hi);
        return x >= {1'b0, lo} && x <= {1'b0, hi};
    endfunction

    function automatic uki_rep_t mkrep(input logic [7:0] s, input logic [31:0] d,
                                       input logic [31:0] a);
        uki_rep_t r;
        r.res = (s == ST_OK) ? REPLY_OK : REPLY_ERR;
        r.sts = s;
        r.st2 = d;
        r.adr = a;
        return r;
    endfunction

    function automatic logic [7:0] rbyte(input uki_rep_t r, input logic [3:0] i,
                                         input logic [7:0] s);
        case (i)
            4'h0: return DATA_PACKET_START_BYTE;
            4'h1: return REP_LEN[15:8];
            4'h2: return REP_LEN[7:0];
            4'h3: return r.res;
            4'h4: return r.sts;
            4'h5: return r.st2[31:24];
            4'h6: return r.st2[23:16];
            4'h7: return r.st2[15:8];
            4'h8: return r.st2[7:0];
            4'h9: return r.adr[31:24];
            4'hA: return r.adr[23:16];
            4'hB: return r.adr[15:8];
            4'hC: return r.adr[7:0];
            4'hD: return 8'h00 - s;
            default: return END_BYTE;
        endcase
    endfunction

    // span and area decode for the requested key store location
    always_comb begin
        isz  = uki_isize(ctype_q);
        ksz  = {1'b0, isz} + KIDX_EXTRA;
        sb   = {1'b0, key_store_location_q};
        se   = sb + {21'd0, ksz} - 33'd1;
        s0   = inr(sb, rg_q[R_A0LO], rg_q[R_A0HI]);
        s1   = inr(sb, rg_q[R_A1LO], rg_q[R_A1HI]);
        e0   = inr(se, rg_q[R_A0LO], rg_q[R_A0HI]);
        e1   = inr(se, rg_q[R_A1LO], rg_q[R_A1HI]);
        fits = (s0 || s1) && (e0 || e1);
        same = (s0 && e0) || (s1 && e1) ||
               (rg_q[R_CFG][F_KIND0] == rg_q[R_CFG][F_KIND1]);
        write_access_unit  = s0 ? rg_q[R_CFG][F_WAU0 +: 8] : rg_q[R_CFG][F_WAU1 +: 8];
        acc  = inr(sb, rg_q[R_ACCLO], rg_q[R_ACCHI]) &&
               inr(se, rg_q[R_ACCLO], rg_q[R_ACCHI]);
        sec  = sb < {1'b0, rg_q[R_SECEND]};
        prot = rg_q[R_CFG][F_PREN] && !(se < {1'b0, rg_q[R_PRLO]}) &&
               !(sb > {1'b0, rg_q[R_PRHI]});
        tot  = 17'(cnt_q) + 17'(len_q) - 17'd1;
        wpos = 17'(cnt_q) + 17'(ix_q) - 17'd1;
    end

    // fixed priority of every failure found at evaluation; trusted-system and flash failures come later
    always_comb begin
        ev_sts = ST_OK;
        if (!etx_ok_q) begin
            ev_sts = ST_PKT;
        end else if (!sum_ok_q) begin
            ev_sts = ST_SUM;
        end else if (len_q == 16'h0000 || len_q > MAX_LEN) begin
            ev_sts = ST_PKT;
        end else if (!dm_q) begin
            if (len_q != CMD_LEN) begin
                ev_sts = ST_PKT;
            end else if (!lc_ok) begin
                ev_sts = ST_ACC;
            end else if (isz == 11'd0) begin
                ev_sts = ST_PAR;
            end else if (!fits || !same || se[32]) begin
                ev_sts = ST_PAR;
            end else if (write_access_unit == 8'h00) begin
                ev_sts = ST_PAR;
            end else if ((key_store_location_q[7:0] & (write_access_unit - 8'h01)) != 8'h00) begin
                ev_sts = ST_PAR;
            end else if (!acc) begin
                ev_sts = ST_ADR;
            end else if ((auth_lvl == AL1 && sec) || auth_lvl == AL0) begin
                ev_sts = ST_SEC;
            end else if (prot) begin
                ev_sts = ST_PROT;
            end
        end else if (dres_q != REPLY_OK) begin
            ev_sts = ST_PKT;
        end else if (tot > {6'd0, isz}) begin
            ev_sts = ST_PAR;
        end
    end

    assign tx_done = tx_valid && tx_ready && tix_q == REP_LAST;

    // command and data sequencing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= S_IDLE;
            dm_q      <= 1'b0;
            go_data_q <= 1'b0;
            rep_q     <= '0;
            cnt_q     <= 11'd0;
            ts_start  <= 1'b0;
            fl_start  <= 1'b0;
            fl_addr   <= 32'h0000_0000;
            fl_len    <= 12'h000;
        end else begin
            ts_start <= 1'b0;
            fl_start <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (rx_valid && rx_data == (dm_q ? DATA_PACKET_START_BYTE
                                                     : CMD_START_BYTE)) begin
                        st_q <= S_LNH;
                    end
                end
                S_LNH: begin
                    if (rx_valid) begin
                        st_q <= S_LNL;
                    end
                end
                S_LNL: begin
                    if (rx_valid) begin
                        st_q <= ({len_q[15:8], rx_data} == 16'h0000) ? S_SUM : S_BODY;
                    end
                end
                S_BODY: begin
                    if (rx_valid && ix_q == len_q - 16'h0001) begin
                        st_q <= S_SUM;
                    end
                end
                S_SUM: begin
                    if (rx_valid) begin
                        st_q <= S_ETX;
                    end
                end
                S_ETX: begin
                    if (rx_valid) begin
                        st_q <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    if (ev_sts != ST_OK) begin
                        rep_q     <= mkrep(ev_sts, FILLER, FILLER);
                        go_data_q <= 1'b0;
                        st_q      <= S_TX;
                    end else if (!dm_q) begin
                        rep_q     <= mkrep(ST_OK, FILLER, FILLER);
                        go_data_q <= 1'b1;
                        cnt_q     <= 11'd0;
                        st_q      <= S_TX;
                    end else if (tot == {6'd0, isz}) begin
                        cnt_q    <= tot[10:0];
                        ts_start <= 1'b1;
                        st_q     <= S_TS;
                    end else begin
                        cnt_q <= tot[10:0];
                        st_q  <= S_IDLE;
                    end
                end
                S_TS: begin
                    if (ts_done) begin
                        if (ts_abn) begin
                            dm_q <= 1'b0;
                            st_q <= S_IDLE;
                        end else if (ts_fail) begin
                            rep_q     <= mkrep(ST_TS, FILLER, FILLER);
                            go_data_q <= 1'b0;
                            st_q      <= S_TX;
                        end else begin
                            fl_start <= 1'b1;
                            fl_addr  <= key_store_location_q;
                            fl_len   <= ksz;
                            st_q     <= S_FL;
                        end
                    end
                end
                S_FL: begin
                    if (fl_done) begin
                        go_data_q <= 1'b0;
                        st_q      <= S_TX;
                        if (fl_err) begin
                            rep_q <= mkrep(ST_FL, fl_sts, fl_fadr);
                        end else begin
                            rep_q <= mkrep(ST_OK, FILLER, FILLER);
                        end
                    end
                end
                S_TX: begin
                    if (tx_done) begin
                        dm_q <= go_data_q;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // packet field capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            len_q    <= 16'h0000;
            ix_q     <= 16'h0000;
            sum_q    <= 8'h00;
            ctype_q  <= 8'h00;
            dres_q   <= 8'h00;
            key_store_location_q   <= 32'h0000_0000;
            etx_ok_q <= 1'b0;
            sum_ok_q <= 1'b0;
        end else if (rx_valid) begin
            case (st_q)
                S_LNH: begin
                    len_q[15:8] <= rx_data;
                    sum_q       <= rx_data;
                end
                S_LNL: begin
                    len_q[7:0] <= rx_data;
                    sum_q      <= sum_q + rx_data;
                    ix_q       <= 16'h0000;
                end
                S_BODY: begin
                    sum_q <= sum_q + rx_data;
                    ix_q  <= ix_q + 16'h0001;
                    if (!dm_q && ix_q == 16'h0001) begin
                        ctype_q <= rx_data;
                    end
                    if (!dm_q && ix_q > 16'h0001) begin
                        key_store_location_q <= {key_store_location_q[23:0], rx_data};
                    end
                    if (dm_q && ix_q == 16'h0000) begin
                        dres_q <= rx_data;
                    end
                end
                S_SUM: sum_ok_q <= (sum_q + rx_data) == 8'h00;
                S_ETX: etx_ok_q <= rx_data == END_BYTE;
                default: ;
            endcase
        end
    end

    // payload buffer; only flash is guarded, the buffer may hold rejected bytes
    always_ff @(posedge mclk) begin
        if (st_q == S_BODY && rx_valid && dm_q && ix_q != 16'h0000 &&
            wpos < 17'(KB_DEPTH)) begin
            kb_q[wpos[10:0]] <= rx_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            kb_data  <= 8'h00;
            ts_ktype <= 8'h00;
        end else begin
            kb_data  <= (32'(kb_addr) < KB_DEPTH) ? kb_q[kb_addr] : 8'h00;
            ts_ktype <= ctype_q;
        end
    end

    // status reply serialiser with running checksum
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tix_q    <= 4'h0;
            tsum_q   <= 8'h00;
        end else if (st_q != S_TX) begin
            tx_valid <= 1'b0;
            tix_q    <= 4'h0;
            tsum_q   <= 8'h00;
        end else if (!tx_valid && tix_q == 4'h0) begin
            tx_valid <= 1'b1;
            tx_data  <= rbyte(rep_q, 4'h0, 8'h00);
        end else if (tx_valid && tx_ready) begin
            if (tix_q == REP_LAST) begin
                tx_valid <= 1'b0;
            end else begin
                tix_q   <= tix_q + 4'h1;
                tx_data <= rbyte(rep_q, tix_q + 4'h1, tsum_q);
                if (tix_q + 4'h1 < REP_SUM_IX) begin
                    tsum_q <= tsum_q + rbyte(rep_q, tix_q + 4'h1, tsum_q);
                end
            end
        end
    end

    // apb slave, no wait states
    assign ri  = paddr[5:2];
    assign bad = paddr[11:6] != 6'd0 || paddr[1:0] != 2'd0 || 32'(ri) >= NREG;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            for (int i = 0; i < NREG - 1; i++) begin
                rg_q[i] <= 32'h0000_0000;
            end
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                pslverr <= bad;
                if (bad) begin
                    prdata <= 32'h0000_0000;
                end else if (ri == R_STAT) begin
                    prdata <= {20'd0, st_q, rep_q.sts};
                end else begin
                    prdata <= rg_q[ri];
                end
            end
            if (psel && penable && pready && pwrite && !bad && ri != R_STAT) begin
                rg_q[ri] <= pwdata;
            end
        end
    end

    a_start_hunt: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == S_IDLE && rx_valid && rx_data != CMD_START_BYTE && !dm_q
        |=> st_q == S_IDLE) else $error("non-header byte left idle");
    a_etx_first: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == S_EVAL && !etx_ok_q |=> st_q == S_TX && rep_q.sts == ST_PKT)
        else $error("missing terminator not reported first");
    a_sum_second: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == S_EVAL && etx_ok_q && !sum_ok_q |=> rep_q.sts == ST_SUM)
        else $error("checksum error not reported");
    a_err_no_data: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == S_EVAL && ev_sts != ST_OK |=> !go_data_q ##0 !fl_start [*2])
        else $error("failure did not abandon command");
    a_ts_full: assert property (@(posedge mclk) disable iff (!rst_n)
        ts_start |-> cnt_q == isz && st_q == S_TS)
        else $error("index generation before full payload");
    a_abn_silent: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == S_TS && ts_done && ts_abn |=> st_q == S_IDLE && !tx_valid && !fl_start)
        else $error("abnormal trusted system still answered");
    a_fl_report: assert property (@(posedge mclk) disable iff (!rst_n)
        st_q == S_FL && fl_done && fl_err
        |=> rep_q.sts == ST_FL && rep_q.adr == $past(fl_fadr) && rep_q.st2 == $past(fl_sts))
        else $error("flash failure detail wrong");
    a_reply_head: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(tx_valid) |-> tx_data == DATA_PACKET_START_BYTE && tix_q == 4'h0)
        else $error("reply does not open with start byte");
    a_tx_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped under stall");
endmodule

/* rtl/uki_pkg.sv */
package uki_pkg;
    localparam logic [7:0]  CMD_START_BYTE         = 8'h01;
    localparam logic [7:0]  DATA_PACKET_START_BYTE = 8'h81;
    localparam logic [7:0]  END_BYTE               = 8'h03;
    localparam logic [7:0]  REPLY_OK               = 8'h2A;
    localparam logic [7:0]  REPLY_ERR              = 8'hAA;
    // status code values are arbitrary except ok
    localparam logic [7:0]  ST_OK                  = 8'h00;
    localparam logic [7:0]  ST_PKT                 = 8'hC1;
    localparam logic [7:0]  ST_SUM                 = 8'hC2;
    localparam logic [7:0]  ST_ACC                 = 8'hC3;
    localparam logic [7:0]  ST_PAR                 = 8'hC4;
    localparam logic [7:0]  ST_ADR                 = 8'hD0;
    localparam logic [7:0]  ST_SEC                 = 8'hD1;
    localparam logic [7:0]  ST_PROT                = 8'hD2;
    localparam logic [7:0]  ST_TS                  = 8'hD3;
    localparam logic [7:0]  ST_FL                  = 8'hE0;
    localparam logic [31:0] FILLER                 = 32'hFFFF_FFFF;
    localparam logic [15:0] CMD_LEN                = 16'h0006;
    localparam logic [15:0] MAX_LEN                = 16'h0401;
    localparam logic [15:0] REP_LEN                = 16'h000A;
    localparam logic [3:0]  REP_SUM_IX             = 4'hD;
    localparam logic [3:0]  REP_LAST               = 4'hE;
    localparam logic [1:0]  AL0                    = 2'h0;
    localparam logic [1:0]  AL1                    = 2'h1;
    localparam logic [11:0] KIDX_EXTRA             = 12'h004;
    localparam int          NREG                   = 11;
    localparam logic [3:0]  R_A0LO  = 4'h0;
    localparam logic [3:0]  R_A0HI  = 4'h1;
    localparam logic [3:0]  R_A1LO  = 4'h2;
    localparam logic [3:0]  R_A1HI  = 4'h3;
    localparam logic [3:0]  R_CFG   = 4'h4;
    localparam logic [3:0]  R_ACCLO = 4'h5;
    localparam logic [3:0]  R_ACCHI = 4'h6;
    localparam logic [3:0]  R_SECEND = 4'h7;
    localparam logic [3:0]  R_PRLO  = 4'h8;
    localparam logic [3:0]  R_PRHI  = 4'h9;
    localparam logic [3:0]  R_STAT  = 4'hA;
    localparam int          F_WAU0  = 0;
    localparam int          F_WAU1  = 8;
    localparam int          F_KIND0 = 16;
    localparam int          F_KIND1 = 17;
    localparam int          F_PREN  = 18;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000, S_LNH = 4'b0001, S_LNL = 4'b0010, S_BODY = 4'b0011,
        S_SUM  = 4'b0100, S_ETX = 4'b0101, S_EVAL = 4'b0110, S_TS = 4'b0111,
        S_FL   = 4'b1000, S_TX  = 4'b1001
    } uki_st_t;

    typedef struct packed {
        logic [7:0]  res;
        logic [7:0]  sts;
        logic [31:0] st2;
        logic [31:0] adr;
    } uki_rep_t;

    // install size per user key type, zero when unsupported
    function automatic logic [10:0] uki_isize(input logic [7:0] t);
        case (t)
            8'h05: return 11'd32;
            8'h06, 8'h07, 8'h08, 8'h13, 8'h15, 8'h17, 8'h1A, 8'h1B, 8'h1D,
            8'h23, 8'h26, 8'h27, 8'hFF: return 11'd48;
            8'h19, 8'h1F, 8'h28: return 11'd64;
            8'h09, 8'h12, 8'h14, 8'h16, 8'h1C, 8'h21, 8'h22, 8'h29, 8'h2A,
            8'h2B: return 11'd80;
            8'h25: return 11'd96;
            8'h18, 8'h1E: return 11'd112;
            8'h20: return 11'd144;
            8'h0A: return 11'd160;
            8'h24: return 11'd176;
            8'h0B: return 11'd272;
            8'h0C, 8'hFE: return 11'd288;
            8'h0E: return 11'd416;
            8'h0D: return 11'd528;
            8'h10: return 11'd544;
            8'h0F: return 11'd784;
            8'h11: return 11'd1040;
            default: return 11'd0;
        endcase
    endfunction
endpackage

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
    import uki_pkg::*;
;
    localparam logic [31:0] FSTS = 32'h0000_5a5a, FADR = 32'h0000_0104;
    logic        mclk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, lc_ok, pready, pslverr, er;
    logic        rx_valid, tx_valid, tx_ready, ts_start, ts_done, fl_start, fl_done, fl_err;
    logic [1:0]  auth_lvl;
    logic        ts_fail, ts_abn;
    logic [7:0]  pay[$];
    logic [7:0]  rx_data, tx_data, ts_ktype, kb_data;
    logic [10:0] kb_addr, ka;
    logic [11:0] paddr, fl_len;
    logic [31:0] pwdata, prdata, fl_addr, rd, seed = 32'h7167_fed8;
    int          num_errors = 0, compares = 0, ok[7] = '{1, 0, 0, 1, 2, 5, 256};
    int          tab[10][7] = '{'{0, 1, 0, 1, 2, 5, 256}, '{1, 1, 0, 1, 2, 5, 256},
        '{1, 0, 1, 1, 2, 5, 256}, '{1, 0, 0, 0, 2, 0, 256}, '{1, 0, 0, 1, 2, 0, 256},
        '{1, 0, 0, 1, 2, 44, 256}, '{1, 0, 0, 1, 2, 5, 4080}, '{1, 0, 0, 1, 2, 5, 258},
        '{1, 0, 0, 1, 2, 5, 2048}, '{1, 0, 0, 1, 0, 5, 256}};
    uki_key_install uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .lc_ok(lc_ok), .auth_lvl(auth_lvl),
        .ts_start(ts_start), .ts_ktype(ts_ktype), .ts_done(ts_done), .ts_fail(ts_fail),
        .ts_abn(ts_abn), .kb_addr(kb_addr), .kb_data(kb_data), .fl_start(fl_start),
        .fl_addr(fl_addr), .fl_len(fl_len), .fl_done(fl_done), .fl_err(fl_err),
        .fl_sts(FSTS), .fl_fadr(FADR));
    uki_host host (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    always #25 mclk = ~mclk;
    function automatic logic [7:0] rb();
        seed = {seed[30:0], ^(seed & 32'h8020_0003)};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] model(input int t[7]);
        if (t[0] == 0 || t[1] != 0) return t[0] == 0 ? ST_PKT : ST_SUM;
        if (t[2] != 0) return ST_PKT;
        if (t[3] == 0) return ST_ACC;
        if (!(t[5] inside {[5:43], 254, 255}) || t[6] + 35 > 4095 || t[6] % 4 != 0) return ST_PAR;
        if (t[6] + 35 > 2047) return ST_ADR;
        return t[4] == 0 ? ST_SEC : ST_OK;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic pkt(input logic [7:0] st, input logic [7:0] b[$], input logic [7:0] skew,
                       input int etx);
        logic [7:0] q[$], s, g;
        g = rb();
        s = 8'(b.size() >> 8) + 8'(b.size());
        foreach (b[i]) s += b[i];
        q = {8'h40 | (g & 8'h3f), st, 8'(b.size() >> 8), 8'(b.size()), b, 8'(skew - s)};
        q.push_back(etx != 0 ? END_BYTE : 8'h55);
        host.send(q);
    endtask
    task automatic cmd(input int t[7]);
        logic [7:0] b[$];
        {lc_ok, auth_lvl} <= {t[3][0], t[4][1:0]};
        b = {8'h28, 8'(t[5]), 8'(t[6] >> 24), 8'(t[6] >> 16), 8'(t[6] >> 8), 8'(t[6])};
        pay.delete();
        if (t[2] != 0) b.pop_back();
        pkt(CMD_START_BYTE, b, 8'(t[1]), t[0]);
    endtask
    task automatic data(input int n);
        logic [7:0] b[$];
        b = {REPLY_OK};
        repeat (n) b.push_back(rb());
        pay = {pay, b[1:$]};
        pkt(DATA_PACKET_START_BYTE, b, 8'h00, 1);
    endtask
    task automatic reply(input logic [7:0] sts, input logic [31:0] st2, input logic [31:0] adr);
        int n = 0;
        logic [7:0] s = 8'h00;
        while (host.got.size() < 15 && n < 500) begin
            @(posedge mclk);
            n++;
        end
        for (int i = 1; i < 14; i++) s += host.got[i];
        chk(32'(s), 32'h0000_0000);
        chk({host.got[0], host.got[3], host.got[4], host.got[14]},
            {8'h81, (sts == ST_OK) ? REPLY_OK : REPLY_ERR, sts, END_BYTE});
        chk({host.got[5], host.got[6], host.got[7], host.got[8]}, st2);
        chk({host.got[9], host.got[10], host.got[11], host.got[12]}, adr);
        host.got.delete();
    endtask
    always @(posedge mclk) begin
        {ts_done, fl_done, kb_addr, ka} <= {ts_start, fl_start, 6'd0, seed[4:0], kb_addr};
        if (ts_start === 1'b1) chk(32'(ts_ktype), 32'(ok[5]));
        if (ts_start === 1'b1) chk(32'(kb_data), 32'(pay[ka]));
        if (fl_start === 1'b1) chk({fl_len, fl_addr[19:0]}, {12'h024, 20'h0_0100});
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, lc_ok, auth_lvl, fl_err} = '0;
        {ts_done, fl_done, kb_addr, ts_fail, ts_abn} = '0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b1, 12'h004, 32'h0000_0fff);
        apb(1'b1, 12'h010, 32'h0000_0004);
        apb(1'b1, 12'h018, 32'h0000_07ff);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
        foreach (tab[i]) begin
            cmd(tab[i]);
            reply(model(tab[i]), FILLER, FILLER);
        end
        for (int r = 0; r < 5; r++) begin
            {fl_err, ts_fail, ts_abn} <= {r == 1, r == 3, r == 4};
            ok[5] = (r == 3) ? 17 : 5;
            cmd(ok);
            reply(ST_OK, FILLER, FILLER);
            data(r == 0 ? 16 : (r == 3 ? 972 : (r == 2 ? 33 : 32)));
            if (r == 0 || r == 4) begin
                repeat (60) @(posedge mclk);
                chk(32'(host.got.size()), 32'h0000_0000);
            end
            if (r == 0) data(16);
            if (r == 3) data(68);
            if (r != 4)
                reply(r == 0 ? ST_OK : (r == 1 ? ST_FL : (r == 2 ? ST_PAR : ST_TS)),
                      r == 1 ? FSTS : FILLER, r == 1 ? FADR : FILLER);
        end
        apb(1'b1, 12'h024, 32'h0000_0200);
        apb(1'b1, 12'h010, 32'h0004_0004);
        cmd(ok);
        reply(ST_PROT, FILLER, FILLER);
        summarize();
    end
    initial begin
        #1_000_000;
        num_errors++;
        summarize();
    end
endmodule

/* testbench/uki_host.sv */
`timescale 1ns/1ps
module uki_host (
    input  wire logic       mclk,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] got[$];
    initial {rx_valid, rx_data, tx_ready} = '0;
    // stalls every other cycle so each reply byte must hold
    always @(posedge mclk) begin
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready) got.push_back(tx_data);
    end
    task automatic send(input logic [7:0] pkt[$]);
        foreach (pkt[i]) begin
            @(posedge mclk);
            {rx_valid, rx_data} <= {1'b1, pkt[i]};
        end
        @(posedge mclk);
        // released line must not keep showing the last byte
        {rx_valid, rx_data} <= {1'b0, ~rx_data};
    endtask
endmodule
